// *** sld_drive.sv ***
// Segment display drive timing top with APB register slave
`timescale 1ns/1ns
module sld_drive #(
   parameter int QUARTER = sld_pkg::QUARTER_CYCLES,
   parameter int NSEG    = sld_pkg::SEG_PINS,
   parameter int NKS     = sld_pkg::KS_PINS
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Chip-enable reset and halt indications
   input  wire logic              ce_reset,
   input  wire logic              halt,
   // Glass drive
   output logic      [1:0]        backplane_drive_0,
   output logic      [1:0]        backplane_drive_1,
   output logic      [NSEG-1:0]   seg_out,
   output logic                   key_scan_slot
);
   // Register state
   logic [3:0]      mode_reg;
   logic [NSEG-1:0] seg_a_reg;
   logic [NSEG-1:0] seg_b_reg;
   logic [1:0]      port_sel_reg;
   logic [NKS-1:0]  ks_data_reg;
   logic [NSEG-1:0] port_hold_reg;
   logic [31:0]     prdata_reg;
   logic            pready_reg;
   logic            pslverr_reg;

   // Output state
   logic [1:0]      bp0_reg;
   logic [1:0]      bp1_reg;
   logic [NSEG-1:0] seg_reg;
   logic            ks_slot_reg;
   logic            run_reg;

   sld_tick_if tif ();

   sld_phase_gen #(
      .QUARTER (QUARTER)
   ) u_phase (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .tif     (tif)
   );

   // 250 Hz display clock, toggled by every quarter tick
   logic       disp_clk_reg;
   // Frame count lets software pace data updates to whole frames
   logic [7:0] frame_cnt_reg;

   always_ff @(posedge sys_clk) begin
      if (!resetn || !run_reg)
         disp_clk_reg <= 1'b0;
      else if (tif.tick)
         disp_clk_reg <= !disp_clk_reg;
   end

   // The tick lands with the new phase, so phase zero marks a frame start
   always_ff @(posedge sys_clk) begin
      if (!resetn || !run_reg)
         frame_cnt_reg <= 8'h0;
      else if (tif.tick && tif.phase == 2'h0)
         frame_cnt_reg <= frame_cnt_reg + 8'h1;
   end

   // Each register claims only its own exact byte address
   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] want);
      addr_hit = (a == want);
   endfunction : addr_hit

   // Register decode
   wire access     = psel && penable && !pready_reg;
   // Writes land on the edge where the master sees pready high
   wire wr_en      = psel && penable && pwrite && pready_reg;
   wire hit_mode   = addr_hit(paddr, sld_pkg::MODE_ADDR);
   wire hit_seg_a  = addr_hit(paddr, sld_pkg::SEG_A_ADDR);
   wire hit_seg_b  = addr_hit(paddr, sld_pkg::SEG_B_ADDR);
   wire hit_port   = addr_hit(paddr, sld_pkg::PORT_SEL_ADDR);
   wire hit_ks     = addr_hit(paddr, sld_pkg::KS_DATA_ADDR);
   wire hit_stat   = addr_hit(paddr, sld_pkg::STATUS_ADDR);
   wire hit_any    = hit_mode || hit_seg_a || hit_seg_b || hit_port || hit_ks || hit_stat;
   wire disp_en    = mode_reg[sld_pkg::DISP_EN_POS];
   wire ks_en      = mode_reg[sld_pkg::KS_EN_POS];
   wire grp_low    = port_sel_reg[0];
   wire grp_up     = port_sel_reg[1];
   wire port_group_lower = grp_low;
   wire port_group_upper = grp_up;
   wire wr_mode    = wr_en && hit_mode;
   wire wr_port    = wr_en && hit_port;
   wire wr_seg_a   = wr_en && hit_seg_a;
   wire wr_seg_b   = wr_en && hit_seg_b;
   wire wr_ks      = wr_en && hit_ks;
   // Upper mode bits are reserved and always read zero
   wire [3:0] mode_next = {2'h0, pwdata[sld_pkg::KS_EN_POS], pwdata[sld_pkg::DISP_EN_POS]};

   // Status: frame count, display clock, key slot, drive running, phase
   wire [31:0] status_word =
      {19'h0, frame_cnt_reg, disp_clk_reg, ks_slot_reg, run_reg, tif.phase};

   // Narrow registers read back zero-extended
   wire [31:0] mode_word   = {28'h0, mode_reg};
   wire [31:0] seg_a_word  = 32'(seg_a_reg);
   wire [31:0] seg_b_word  = 32'(seg_b_reg);
   wire [31:0] port_word   = {30'h0, port_sel_reg};
   wire [31:0] ks_word     = 32'(ks_data_reg);

   wire [31:0] rd_word =
      hit_mode  ? mode_word :
      hit_seg_a ? seg_a_word :
      hit_seg_b ? seg_b_word :
      hit_port  ? port_word :
      hit_ks    ? ks_word :
      hit_stat  ? status_word : 32'h0;
   // Read data is zero outside its answer cycle
   wire [31:0] rd_next = (access && !pwrite) ? rd_word : 32'h0;

   // APB answers one cycle after the access phase opens
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         pready_reg <= 1'b0;
      else
         pready_reg <= access;
   end

   // Error only on an address that no register claims
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         pslverr_reg <= 1'b0;
      else
         pslverr_reg <= access && !hit_any;
   end

   // Registered read data
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         prdata_reg <= 32'h0;
      else
         prdata_reg <= rd_next;
   end

   // Reset to key scan and display off
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         mode_reg <= sld_pkg::MODE_RESET;
      else if (wr_mode)
         mode_reg <= mode_next;
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn)
         port_sel_reg <= sld_pkg::PORT_SEL_RESET;
      else if (wr_port)
         port_sel_reg <= pwdata[1:0];
   end

   // Dot data for backplane 0, also the port levels
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         seg_a_reg <= '0;
      else if (wr_seg_a)
         seg_a_reg <= pwdata[NSEG-1:0];
   end

   // Dot data for backplane 1
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         seg_b_reg <= '0;
      else if (wr_seg_b)
         seg_b_reg <= pwdata[NSEG-1:0];
   end

   // Key values for the shared pins
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         ks_data_reg <= '0;
      else if (wr_ks)
         ks_data_reg <= pwdata[NKS-1:0];
   end

   // Level of one backplane in a quarter phase; own phase is quarters 0,1 or 2,3
   function automatic logic [1:0] bp_level(input logic [1:0] ph, input logic which);
      logic selected;
      selected = (ph[1] == which);
      if (!selected)
         bp_level = sld_pkg::LVL_MID;
      else
         bp_level = ph[0] ? sld_pkg::LVL_LOW : sld_pkg::LVL_HIGH;
   endfunction : bp_level

   // One of four phase patterns from the dot pair, bit n for quarter n
   function automatic logic [3:0] seg_pattern(input logic dot_a, input logic dot_b);
      unique case ({dot_b, dot_a})
         2'b00:   seg_pattern = 4'b0101;
         2'b01:   seg_pattern = 4'b0110;
         2'b10:   seg_pattern = 4'b1001;
         2'b11:   seg_pattern = 4'b1010;
      endcase
   endfunction : seg_pattern

   // Two-level pin value in quarter ph
   function automatic logic seg_level(input logic [1:0] ph, input logic dot_a,
                                      input logic dot_b);
      logic [3:0] pat;
      pat       = seg_pattern(dot_a, dot_b);
      seg_level = pat[ph];
   endfunction : seg_level

   // Drive keeps running through halt and chip-enable reset
   wire run_next = disp_en;

   // Key slots need a running drive and the key-scan enable
   wire ks_active    = run_reg && ks_en;
   // Key slot takes the odd quarter of each 250 Hz clock period
   wire odd_quarter  = tif.phase[0];
   wire ks_slot_next = ks_active && odd_quarter;

   logic [NSEG-1:0] seg_wave;
   logic [NSEG-1:0] seg_next;

   always_comb begin
      for (int i = 0; i < NSEG; i++) begin
         seg_wave[i] = seg_level(tif.phase, seg_a_reg[i], seg_b_reg[i]);
      end
   end

   // Halt and chip-enable reset freeze only the port pins
   wire frozen = halt || ce_reset;

   // Port group level; data written during a freeze waits for its end
   function automatic logic [sld_pkg::GRP_W-1:0] port_pick(input logic frz,
      input logic [sld_pkg::GRP_W-1:0] held, input logic [sld_pkg::GRP_W-1:0] live);
      port_pick = frz ? held : live;
   endfunction : port_pick

   always_comb begin
      seg_next = seg_wave;
      if (ks_slot_next)
         seg_next[NKS-1:0] = ks_data_reg;
      if (!run_reg)
         seg_next = '0;
      // Port groups static from data bits
      if (port_group_lower)
         seg_next[sld_pkg::GRP_LOW_POS +: sld_pkg::GRP_W] =
            port_pick(frozen, port_hold_reg[sld_pkg::GRP_LOW_POS +: sld_pkg::GRP_W],
                      seg_a_reg[sld_pkg::GRP_LOW_POS +: sld_pkg::GRP_W]);
      if (port_group_upper)
         seg_next[sld_pkg::GRP_UP_POS +: sld_pkg::GRP_W] =
            port_pick(frozen, port_hold_reg[sld_pkg::GRP_UP_POS +: sld_pkg::GRP_W],
                      seg_a_reg[sld_pkg::GRP_UP_POS +: sld_pkg::GRP_W]);
   end

   // Port levels frozen while halted; only port bits matter here
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         port_hold_reg <= '0;
      else if (!frozen)
         port_hold_reg <= seg_a_reg;
   end

   assign tif.run = run_reg;

   // Drive state follows the enable one cycle late
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         run_reg <= 1'b0;
      else
         run_reg <= run_next;
   end

   // Backplanes fall to low as soon as the drive stops
   wire [1:0] bp0_next = run_reg ? bp_level(tif.phase, 1'b0) : sld_pkg::LVL_LOW;
   wire [1:0] bp1_next = run_reg ? bp_level(tif.phase, 1'b1) : sld_pkg::LVL_LOW;

   // Backplane 0 owns quarters 0 and 1
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         bp0_reg <= sld_pkg::LVL_LOW;
      else
         bp0_reg <= bp0_next;
   end

   // Backplane 1 owns quarters 2 and 3
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         bp1_reg <= sld_pkg::LVL_LOW;
      else
         bp1_reg <= bp1_next;
   end

   // Segment pins leave a flip-flop like every other output
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         seg_reg <= '0;
      else
         seg_reg <= seg_next;
   end

   // Key values only with key-scan enable
   always_ff @(posedge sys_clk) begin
      if (!resetn)
         ks_slot_reg <= 1'b0;
      else
         ks_slot_reg <= ks_slot_next;
   end

   assign prdata            = prdata_reg;
   assign pready            = pready_reg;
   assign pslverr           = pslverr_reg;
   assign backplane_drive_0 = bp0_reg;
   assign backplane_drive_1 = bp1_reg;
   assign seg_out           = seg_reg;
   assign key_scan_slot     = ks_slot_reg;
endmodule : sld_drive

// *** sld_pkg.sv ***
// Constants for the segment display drive timing block
package sld_pkg;
   localparam int          CLK_HZ            = 25000000;
   localparam int          FRAME_HZ          = 125;
   localparam int          DISP_CLK_HZ       = 250;
   // Four quarter-frame phases per frame
   localparam int          PHASES_PER_FRAME  = 4;
   localparam int          QUARTER_CYCLES    = CLK_HZ / (FRAME_HZ * PHASES_PER_FRAME);
   localparam int          SEG_PINS          = 30;
   localparam int          KS_PINS           = 16;
   localparam int          GRP_W             = 4;
   localparam int          GRP_LOW_POS       = 22;
   localparam int          GRP_UP_POS        = 26;
   // Register byte addresses
   localparam logic [7:0]  MODE_ADDR         = 8'h10;
   localparam logic [7:0]  SEG_A_ADDR        = 8'h20;
   localparam logic [7:0]  SEG_B_ADDR        = 8'h24;
   localparam logic [7:0]  PORT_SEL_ADDR     = 8'h28;
   localparam logic [7:0]  KS_DATA_ADDR      = 8'h2c;
   localparam logic [7:0]  STATUS_ADDR       = 8'h30;
   // Mode register fields
   localparam int          DISP_EN_POS       = 0;
   localparam int          KS_EN_POS         = 1;
   localparam logic [3:0]  MODE_RESET        = 4'h0;
   localparam logic [1:0]  PORT_SEL_RESET    = 2'h0;
   // Backplane level codes
   localparam logic [1:0]  LVL_LOW           = 2'h0;
   localparam logic [1:0]  LVL_MID           = 2'h1;
   localparam logic [1:0]  LVL_HIGH          = 2'h2;
endpackage : sld_pkg

// *** sld_tick_if.sv ***
// Phase sequencing signals between the top and the tick generator
`timescale 1ns/1ns
interface sld_tick_if;
   logic       run;
   logic [1:0] phase;
   logic       tick;
   modport gen (input run, output phase, output tick);
   modport use_side (input phase, input tick, output run);
endinterface : sld_tick_if

// *** sld_phase_gen.sv ***
// Quarter-frame tick and phase counter for the display drive
`timescale 1ns/1ns
module sld_phase_gen #(
   parameter int QUARTER = sld_pkg::QUARTER_CYCLES
) (
   // Clock and reset
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   // Phase sequencing
   sld_tick_if.gen    tif
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic [1:0]  phase_reg;
   logic [1:0]  phase_next;
   logic        tick_reg;
   wire         wrap = (cnt_reg == 32'(QUARTER - 1));

   assign cnt_next   = (!tif.run || wrap) ? 32'h0 : cnt_reg + 32'h1;
   assign phase_next = !tif.run ? 2'h0 : (wrap ? phase_reg + 2'h1 : phase_reg);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cnt_reg   <= 32'h0;
         phase_reg <= 2'h0;
         tick_reg  <= 1'b0;
      end else begin
         cnt_reg   <= cnt_next;
         phase_reg <= phase_next;
         tick_reg  <= tif.run && wrap;
      end
   end

   assign tif.phase = phase_reg;
   assign tif.tick  = tick_reg;
endmodule : sld_phase_gen

// *** sld_glass_model.sv ***
// Behavioural two-backplane glass that records which dots see full drive
`timescale 1ns/1ns
module sld_glass_model (
   // Drive from the block
   input  wire logic [1:0]  bp0,
   input  wire logic [1:0]  bp1,
   input  wire logic [29:0] seg,
   // Dot states on the glass
   output logic      [29:0] lit_a,
   output logic      [29:0] lit_b
);
   // full swing lights
   // Mid level never lights a dot, so the state is only updated off mid
   always @* begin
      if (bp0 != sld_pkg::LVL_MID) lit_a = (bp0 == sld_pkg::LVL_HIGH) ? ~seg : seg;
      if (bp1 != sld_pkg::LVL_MID) lit_b = (bp1 == sld_pkg::LVL_HIGH) ? ~seg : seg;
   end
endmodule : sld_glass_model

// *** sld_drive_chk.sv ***
// Port-level checker for the segment display drive top
`timescale 1ns/1ns
module sld_drive_chk #(
   parameter int QUARTER = 4,
   parameter int NSEG    = 30
) (
   // Clock, reset and bus
   input wire logic            sys_clk,
   input wire logic            resetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [7:0]      paddr,
   input wire logic [31:0]     pwdata,
   input wire logic            pready,
   // Halt indications and glass drive
   input wire logic            ce_reset,
   input wire logic            halt,
   input wire logic [1:0]      backplane_drive_0,
   input wire logic [1:0]      backplane_drive_1,
   input wire logic [NSEG-1:0] seg_out,
   input wire logic            key_scan_slot
);
   logic [31:0] sa_reg, sb_reg, ks_reg;
   logic [1:0]  md_reg, ps_reg, qt_reg;
   logic [3:0]  bp_reg;
   logic [15:0] run_reg;
   logic        n_reg;
   wire  [3:0]  bp      = {backplane_drive_0, backplane_drive_1};
   wire         on      = bp != 4'h0;
   wire         wr_acc  = psel && penable && pwrite && pready;
   wire         busy    = wr_acc || halt || ce_reset;
   // Writes and halts take two cycles to reach the pins, so skip them
   wire         qt      = qt_reg == 2'h0 && !busy;
   wire         hi      = bp[3:2] == sld_pkg::LVL_HIGH || bp[1:0] == sld_pkg::LVL_HIGH;
   wire  [31:0] dots    = (bp[1:0] == sld_pkg::LVL_MID) ? sa_reg : sb_reg;
   wire  [31:0] exp_seg = hi ? ~dots : dots;
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         {md_reg, ps_reg, qt_reg, sa_reg, sb_reg, ks_reg} <= '0;
      end else begin
         qt_reg <= {qt_reg[0], busy};
         if (wr_acc && paddr == sld_pkg::MODE_ADDR) md_reg <= pwdata[1:0];
         if (wr_acc && paddr == sld_pkg::PORT_SEL_ADDR) ps_reg <= pwdata[1:0];
         if (wr_acc && paddr == sld_pkg::SEG_A_ADDR) sa_reg <= pwdata;
         if (wr_acc && paddr == sld_pkg::SEG_B_ADDR) sb_reg <= pwdata;
         if (wr_acc && paddr == sld_pkg::KS_DATA_ADDR) ks_reg <= pwdata;
      end
   end
   // Length of each backplane step, counted only after a full step began
   always_ff @(posedge sys_clk) begin
      bp_reg <= bp;
      if (!resetn || !on) begin
         {run_reg, n_reg} <= '0;
      end else if (bp != bp_reg) begin
         run_reg <= 16'h1;
         n_reg <= bp_reg != 4'h0;
      end else run_reg <= run_reg + 16'h1;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_ph0;
      bp == {sld_pkg::LVL_HIGH, sld_pkg::LVL_MID};
   endsequence
   sequence s_ph1;
      bp == {sld_pkg::LVL_LOW, sld_pkg::LVL_MID};
   endsequence
   a_bp_one_mid: assert property (on |-> bp[3:2] != 2'h3 && bp[1:0] != 2'h3 &&
      ((bp[3:2] == sld_pkg::LVL_MID) != (bp[1:0] == sld_pkg::LVL_MID))) else $error("bp pair");
   a_quarter_len: assert property (on && n_reg && bp != bp_reg |-> run_reg == QUARTER)
      else $error("step length");
   a_phase_order: assert property (s_ph0 ##1 (on && bp != bp_reg) |-> s_ph1)
      else $error("phase order");
   a_seg_pattern: assert property (on && qt && !key_scan_slot |->
      seg_out[21:0] == exp_seg[21:0]) else $error("segment phase");
   a_key_data: assert property (on && qt && key_scan_slot |-> seg_out[15:0] == ks_reg[15:0]
      && seg_out[21:16] == exp_seg[21:16]) else $error("key slot data");
   a_key_slot: assert property (qt && key_scan_slot |-> md_reg[1] && md_reg[0] &&
      (bp[3:2] == sld_pkg::LVL_LOW || bp[1:0] == sld_pkg::LVL_LOW)) else $error("key slot");
   a_blank_low: assert property (qt && !md_reg[0] |-> bp == 4'h0 &&
      seg_out[21:0] == 22'h0 && !key_scan_slot) else $error("blank not low");
   a_port_static: assert property (qt && ps_reg[0] |-> seg_out[25:22] == sa_reg[25:22])
      else $error("port group");
   a_port_hold: assert property ((halt || ce_reset) && $past(halt || ce_reset) &&
      ps_reg == 2'h3 |->
      $stable(seg_out[29:22])) else $error("port hold");
   a_apb_ready: assert property (psel && penable && !pready |=> pready)
      else $error("bus answer");
endmodule : sld_drive_chk
bind sld_drive sld_drive_chk #(.QUARTER(QUARTER), .NSEG(NSEG)) i_chk (.sys_clk(sys_clk),
   .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .pready(pready), .ce_reset(ce_reset), .halt(halt), .seg_out(seg_out),
   .backplane_drive_0(backplane_drive_0), .backplane_drive_1(backplane_drive_1),
   .key_scan_slot(key_scan_slot));

// *** tb_sld_drive.sv ***
// Self-checking bench for the segment display drive top
`timescale 1ns/1ns
module tb_sld_drive;
   localparam int Q = 4;
   logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        ce_reset = 0, halt = 0, pready, pslverr, key_scan_slot, rd_err;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd_data;
   logic [1:0]  bp0, bp1;
   logic [29:0] seg_out, lit_a, lit_b;
   int          n_mismatch = 0, checked = 0, n;
   always #20 sys_clk = ~sys_clk;
   sld_drive #(.QUARTER(Q)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ce_reset(ce_reset), .halt(halt),
      .backplane_drive_0(bp0), .backplane_drive_1(bp1), .seg_out(seg_out),
      .key_scan_slot(key_scan_slot));
   sld_glass_model i_glass (.bp0(bp0), .bp1(bp1), .seg(seg_out), .lit_a(lit_a), .lit_b(lit_b));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic stop_test;
      if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // One bus transfer; holds everything until pready is sampled high or 50 cycles have passed
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd_data = prdata;
      rd_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   initial begin
      #(40 * 3000);
      n_mismatch++;
      stop_test();
   end
   initial begin
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      @(posedge sys_clk);
      chk("backplanes", {bp0, bp1}, 32'h0);
      chk("segments", seg_out, 32'h0);
      apb(1'b1, 8'h3c, 32'hf);
      chk("unmapped error", rd_err, 32'h1);
      apb(1'b0, sld_pkg::MODE_ADDR, 32'h0);
      chk("mode reset", rd_data, 32'h0);
      apb(1'b1, sld_pkg::SEG_A_ADDR, 32'h3333_3333);
      apb(1'b1, sld_pkg::SEG_B_ADDR, 32'h1555_5555);
      apb(1'b1, sld_pkg::MODE_ADDR, 32'hd);
      apb(1'b0, sld_pkg::MODE_ADDR, 32'h0);
      chk("mode read", rd_data, 32'h1);
      repeat (5 * Q) @(posedge sys_clk);
      chk("dots a", lit_a, 32'h3333_3333);
      chk("dots b", lit_b, 32'h1555_5555);
      apb(1'b1, sld_pkg::KS_DATA_ADDR, 32'ha5c3);
      apb(1'b1, sld_pkg::MODE_ADDR, 32'h3);
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (key_scan_slot !== 1'b1 && n < 6 * Q);
      chk("key data", seg_out[15:0], 32'ha5c3);
      apb(1'b1, sld_pkg::PORT_SEL_ADDR, 32'h3);
      apb(1'b0, sld_pkg::PORT_SEL_ADDR, 32'h0);
      chk("port select", rd_data, 32'h3);
      apb(1'b1, sld_pkg::SEG_A_ADDR, 32'h1633_3333);
      // Halt first, then chip-enable reset; port pins must freeze in both
      for (int i = 0; i < 2; i++) begin
         repeat (3) @(posedge sys_clk);
         chk("port pins", seg_out[29:22], 32'h58);
         halt <= (i == 0);
         ce_reset <= (i == 1);
         apb(1'b1, sld_pkg::SEG_A_ADDR, 32'h0);
         repeat (3) @(posedge sys_clk);
         chk("port held", seg_out[29:22], 32'h58);
         halt <= 1'b0;
         ce_reset <= 1'b0;
         repeat (3) @(posedge sys_clk);
         chk("port reload", seg_out[29:22], 32'h0);
         apb(1'b1, sld_pkg::SEG_A_ADDR, 32'h1633_3333);
      end
      apb(1'b1, sld_pkg::MODE_ADDR, 32'h0);
      repeat (3) @(posedge sys_clk);
      chk("blank backplanes", {bp0, bp1}, 32'h0);
      chk("blank segments", seg_out[21:0], 32'h0);
      stop_test();
   end
endmodule : tb_sld_drive
